// File: shared/ipc_pkg.sv
// Package for the interrupt pending clear bank: map, masks, types
package ipc_pkg;
  // ==========================================================
  // Register map (word offsets chosen locally, byte addresses)
  localparam logic [7:0] IPC_ADDR_CLEAR_LOW = 8'h00;
  localparam logic [7:0] IPC_ADDR_CLEAR_HIGH = 8'h04;
  localparam logic [7:0] IPC_ADDR_FORCE_LOW = 8'h08;
  localparam logic [7:0] IPC_ADDR_FORCE_HIGH = 8'h0c;
  localparam logic [7:0] IPC_ADDR_ENABLE_LOW = 8'h10;
  localparam logic [7:0] IPC_ADDR_ENABLE_HIGH = 8'h14;
  // ==========================================================
  // Implemented interrupt lines: 0..12, 14..30 low; 34, 36..57, 60..63 high
  localparam logic [31:0] IPC_MASK_LOW = 32'h7fff_dfff;
  localparam logic [31:0] IPC_MASK_HIGH = 32'hf3ff_fff4;
  localparam logic [63:0] IPC_MASK_ALL = {IPC_MASK_HIGH, IPC_MASK_LOW};
  localparam logic [63:0] IPC_PEND_RESET = 64'h0;
  localparam logic [63:0] IPC_ENABLE_RESET = 64'h0;
  localparam logic [31:0] IPC_READ_ZERO = 32'h0;
  // ==========================================================
  // Software port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ipc_req_s;
endpackage : ipc_pkg

// File: src/ipc_bank.sv
// Interrupt pending clear bank with companion force and enable registers
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] Clear bit n maps to interrupt n for lines 30..14 and 12..0.
// [RULE2] Writing one to an implemented clear bit removes that pending state.
// [RULE3] Clearing an interrupt that is active leaves its state unchanged.
// [RULE4] Writing zero to a clear bit has no effect.
// [RULE5] Reading a clear bit returns the present pending state.
// [RULE6] Force one pends an enabled, not pending line; zero ignored.
// [RULE7] Unassigned bit positions read zero and ignore writes.
module ipc_bank import ipc_pkg::*; #(
  parameter int NUM_IRQ = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Software register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Interrupt lines and core status
  input wire logic [NUM_IRQ-1:0] irq_in,
  input wire logic [NUM_IRQ-1:0] irq_active,
  output logic [NUM_IRQ-1:0] irq_pending
);
  // ==========================================================
  // Request decode
  ipc_req_s req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Places a 32-bit write word into the low or high half of the line vector
  function automatic logic [63:0] ipc_place(input logic hi, input logic [31:0] w);
    ipc_place = hi ? {w, 32'h0} : {32'h0, w};
  endfunction : ipc_place

  logic [63:0] pend_q, pend_d;
  logic [63:0] enable_q;
  logic [63:0] clr_mask, set_mask;

  // Write-one strobes, limited to implemented lines
  always_comb begin
    clr_mask = '0;
    set_mask = '0;
    if (req.wr && req.addr == IPC_ADDR_CLEAR_LOW) begin
      clr_mask = ipc_place(1'b0, req.wdata) & IPC_MASK_ALL; // RULE1 RULE7 RULE4
    end else if (req.wr && req.addr == IPC_ADDR_CLEAR_HIGH) begin
      clr_mask = ipc_place(1'b1, req.wdata) & IPC_MASK_ALL; // RULE7 RULE4
    end else if (req.wr && req.addr == IPC_ADDR_FORCE_LOW) begin
      set_mask = ipc_place(1'b0, req.wdata) & IPC_MASK_ALL; // RULE6
    end else if (req.wr && req.addr == IPC_ADDR_FORCE_HIGH) begin
      set_mask = ipc_place(1'b1, req.wdata) & IPC_MASK_ALL; // RULE6
    end
  end

  // Pending next state; hardware and forced sets win over a same-cycle clear
  logic [63:0] hw_set;
  always_comb begin
    hw_set = {{(64-NUM_IRQ){1'b0}}, irq_in} & IPC_MASK_ALL;
    pend_d = pend_q & ~(clr_mask & ~{{(64-NUM_IRQ){1'b0}}, irq_active}); // RULE2 RULE3
    pend_d = pend_d | (set_mask & enable_q) | (hw_set & enable_q); // RULE6
    pend_d = pend_d & IPC_MASK_ALL; // RULE7
  end

  // Pending state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_q <= IPC_PEND_RESET;
    end else begin
      pend_q <= pend_d;
    end
  end

  // Enable registers steer which lines may pend
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enable_q <= IPC_ENABLE_RESET;
    end else if (req.wr && req.addr == IPC_ADDR_ENABLE_LOW) begin
      enable_q[31:0] <= req.wdata & IPC_MASK_LOW;
    end else if (req.wr && req.addr == IPC_ADDR_ENABLE_HIGH) begin
      enable_q[63:32] <= req.wdata & IPC_MASK_HIGH;
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= IPC_READ_ZERO;
    end else if (!req.rd) begin
      reg_rdata <= IPC_READ_ZERO;
    end else if (req.addr == IPC_ADDR_CLEAR_LOW || req.addr == IPC_ADDR_FORCE_LOW) begin
      reg_rdata <= pend_q[31:0] & IPC_MASK_LOW; // RULE5 RULE7
    end else if (req.addr == IPC_ADDR_CLEAR_HIGH || req.addr == IPC_ADDR_FORCE_HIGH) begin
      reg_rdata <= pend_q[63:32] & IPC_MASK_HIGH; // RULE5 RULE7
    end else if (req.addr == IPC_ADDR_ENABLE_LOW) begin
      reg_rdata <= enable_q[31:0];
    end else if (req.addr == IPC_ADDR_ENABLE_HIGH) begin
      reg_rdata <= enable_q[63:32];
    end else begin
      reg_rdata <= IPC_READ_ZERO;
    end
  end

  // Pending vector to the arbiter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_pending <= '0;
    end else begin
      irq_pending <= pend_d[NUM_IRQ-1:0];
    end
  end

  // ==========================================================
  // Checks
  clear_low_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == IPC_ADDR_CLEAR_LOW && reg_wdata[0] && !irq_active[0]
     && !(irq_in[0] && enable_q[0])) |=> !pend_q[0])
    else $error("clear of line 0 failed"); // RULE2
  active_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == IPC_ADDR_CLEAR_LOW && irq_active[5] && pend_q[5]) |=> pend_q[5])
    else $error("active line lost pending"); // RULE3
  zero_write_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == IPC_ADDR_CLEAR_LOW && !reg_wdata[3] && pend_q[3]) |=> pend_q[3])
    else $error("zero write cleared line"); // RULE4
  read_pend_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_rd && reg_addr == IPC_ADDR_CLEAR_LOW) |=> reg_rdata == ($past(pend_q[31:0]) & IPC_MASK_LOW))
    else $error("read mismatch"); // RULE5
  force_set_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == IPC_ADDR_FORCE_LOW && reg_wdata[14] && enable_q[14]) |=> pend_q[14])
    else $error("force did not pend"); // RULE6
  force_dis_a: assert property (@(posedge clk) disable iff (!rstn)
    (!enable_q[14] && !pend_q[14]) |=> !pend_q[14])
    else $error("disabled line pended"); // RULE6
  hole_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    (pend_q & ~IPC_MASK_ALL) == 64'h0)
    else $error("unassigned bit set"); // RULE7
  map_high_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == IPC_ADDR_CLEAR_LOW && reg_wdata[30] && !irq_active[30]
     && !(irq_in[30] && enable_q[30])) |=> !pend_q[30])
    else $error("line 30 not mapped"); // RULE1

  // ==========================================================
  // High word checks; the high half has holes at 32, 33, 35, 58 and 59,
  // so the probed lines are picked among the implemented ones only
  clear_high_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == IPC_ADDR_CLEAR_HIGH && reg_wdata[2] && !irq_active[34]
     && !(irq_in[34] && enable_q[34])) |=> !pend_q[34])
    else $error("clear of line 34 failed"); // RULE2

  active_high_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == IPC_ADDR_CLEAR_HIGH && irq_active[36] && pend_q[36])
    |=> pend_q[36])
    else $error("active high line lost pending"); // RULE3

  zero_high_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == IPC_ADDR_CLEAR_HIGH && !reg_wdata[28] && pend_q[60])
    |=> pend_q[60])
    else $error("zero write cleared high line"); // RULE4

  read_high_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_rd && reg_addr == IPC_ADDR_CLEAR_HIGH)
    |=> reg_rdata == ($past(pend_q[63:32]) & IPC_MASK_HIGH))
    else $error("high read mismatch"); // RULE5

  // ==========================================================
  // Read port timing: data stands one cycle only, so a late sampler
  // in software glue would see zero rather than stale pending bits
  rdata_idle_a: assert property (@(posedge clk) disable iff (!rstn)
    !reg_rd |=> reg_rdata == IPC_READ_ZERO)
    else $error("read data outside read slot"); // RULE5

  hole_read_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_rd && reg_addr == IPC_ADDR_CLEAR_LOW) |=> (reg_rdata & ~IPC_MASK_LOW) == 32'h0)
    else $error("hole bit read as one"); // RULE7

  hole_force_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == IPC_ADDR_FORCE_LOW && reg_wdata[13]) |=> !pend_q[13])
    else $error("hole bit forced"); // RULE7

  // ==========================================================
  // Set side; a set in the same cycle as a clear must survive,
  // otherwise an edge arriving during a handler's clear is lost
  force_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == IPC_ADDR_FORCE_LOW && !reg_wdata[14] && !pend_q[14]
     && !(irq_in[14] && enable_q[14])) |=> !pend_q[14])
    else $error("zero force pended line"); // RULE6

  set_wins_a: assert property (@(posedge clk) disable iff (!rstn)
    (irq_in[0] && enable_q[0]) |=> pend_q[0])
    else $error("enabled request not pended"); // RULE6

  // ==========================================================
  // Pending state only drops on a clear write to its own bit
  pend_sticky_a: assert property (@(posedge clk) disable iff (!rstn)
    (pend_q[7] && !(reg_wr && reg_addr == IPC_ADDR_CLEAR_LOW && reg_wdata[7]))
    |=> pend_q[7])
    else $error("pending dropped without clear"); // RULE4

  map_low_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == IPC_ADDR_CLEAR_LOW && reg_wdata[12] && !irq_active[12]
     && !(irq_in[12] && enable_q[12])) |=> !pend_q[12])
    else $error("line 12 not mapped"); // RULE1

  // Arbiter view must track the register view cycle for cycle
  out_match_a: assert property (@(posedge clk) disable iff (!rstn)
    irq_pending == pend_q[NUM_IRQ-1:0])
    else $error("pending output differs"); // RULE5
endmodule : ipc_bank

// File: verification/ipc_bank_tb_top.sv
// Self-checking testbench for the interrupt pending clear bank
`timescale 1ns/1ps
module ipc_bank_tb_top;
  import ipc_pkg::*;
  // ==========================================================
  // Ports, reference state, counters
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_d = 1'b0;
  logic [31:0] reg_rdata;
  logic [63:0] irq_in = 64'h0;
  logic [63:0] irq_active = 64'h0;
  logic [63:0] irq_pending;
  logic [63:0] pend = 64'h0;
  logic [63:0] en = 64'h0;
  logic [31:0] exp_q[$];
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  ipc_bank #(.NUM_IRQ(64)) dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_in(irq_in), .irq_active(irq_active), .irq_pending(irq_pending));
  // ==========================================================
  // Compare, verdict, hang guard
  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    checks++;
    if (seen !== want) begin
      mismatches++;
      $display("ERROR %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end
  // Read data stands only in the cycle after the strobe
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) if (rd_d) chk({32'h0, reg_rdata}, {32'h0, exp_q.pop_front()});
  // ==========================================================
  // Bus tasks; the model updates at the edge that takes the write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [63:0] w;
    w = a[2] ? {d, 32'h0} : {32'h0, d};
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a[4]) en = (a[2] ? {d, en[31:0]} : {en[63:32], d}) & IPC_MASK_ALL;
    else if (a[3]) pend = pend | (w & en & IPC_MASK_ALL);
    else pend = pend & ~(w & ~irq_active);
    @(negedge clk);
    chk(irq_pending, pend);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    // Enable words read back masked; anything past the map reads zero
    if (a[7:5] != 3'h0 || (a[4] && a[3])) exp_q.push_back(32'h0);
    else if (a[4]) exp_q.push_back(a[2] ? en[63:32] : en[31:0]);
    else exp_q.push_back(a[2] ? pend[63:32] : pend[31:0]);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd
  // ==========================================================
  // Random enables, forces, line pulses and clears against active lines
  initial begin
    void'($urandom(32'h1043e82c));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(IPC_ADDR_CLEAR_LOW);
    for (int i = 0; i < 8; i++) begin
      wr(IPC_ADDR_ENABLE_LOW, $urandom());
      wr(IPC_ADDR_ENABLE_HIGH, $urandom());
      rd(IPC_ADDR_ENABLE_LOW);
      rd(IPC_ADDR_ENABLE_HIGH);
      wr(IPC_ADDR_FORCE_LOW, $urandom());
      wr(IPC_ADDR_FORCE_HIGH, $urandom());
      @(posedge clk);
      irq_in <= {$urandom(), $urandom()};
      irq_active <= {$urandom(), $urandom()};
      @(posedge clk);
      irq_in <= 64'h0;
      pend = pend | (irq_in & en & IPC_MASK_ALL);
      rd(IPC_ADDR_CLEAR_LOW);
      rd(IPC_ADDR_FORCE_HIGH);
      wr(IPC_ADDR_CLEAR_LOW, 32'h0);
      wr(IPC_ADDR_CLEAR_HIGH, $urandom());
      rd(8'h40);
      wr(IPC_ADDR_CLEAR_LOW, 32'hffff_ffff);
      rd(IPC_ADDR_CLEAR_LOW);
      rd(IPC_ADDR_CLEAR_HIGH);
    end
    stop_test();
  end
endmodule : ipc_bank_tb_top
